// >>> superio_cfg_pkg.sv
package superio_cfg_pkg;

	// bus word offsets (byte address = 4 * word index)
	localparam logic [3:0] WORD_CONFIG_CONTROL = 4'h0;
	localparam logic [3:0] WORD_CONFIG_INDEX = 4'h1;
	localparam logic [3:0] WORD_CONFIG_DATA = 4'h2;
	localparam logic [3:0] WORD_AUX_CONTROL = 4'h3;
	localparam logic [3:0] WORD_PORT_CONTROL = 4'h4;
	localparam logic [3:0] WORD_PIN_STATUS = 4'h5;

	// indexed configuration registers
	localparam logic [7:0] IDX_FLOPPY_SETUP = 8'h05;
	localparam logic [7:0] IDX_DRIVE_TYPE_IDS = 8'h06;
	localparam logic [7:0] IDX_POWER_AND_BOOT_DRIVE = 8'h07;
	localparam logic [7:0] IDX_DECODER_LOW_ADDRESS = 8'h08;

	// values after reset
	localparam logic [7:0] FLOPPY_SETUP_RST = 8'h00;
	localparam logic [7:0] DRIVE_TYPE_IDS_RST = 8'hff;
	localparam logic [7:0] POWER_AND_BOOT_DRIVE_RST = 8'h00;
	localparam logic [7:0] DECODER_LOW_ADDRESS_RST = 8'h00;
	localparam logic [7:0] AUX_CONTROL_RST = 8'h00;
	localparam logic [7:0] PORT_CONTROL_RST = 8'h00;

	// writable bits; the others read as zero
	localparam logic [7:0] FLOPPY_SETUP_MASK = 8'h7f;
	localparam logic [7:0] POWER_AND_BOOT_DRIVE_MASK = 8'hf3;
	localparam logic [7:0] DECODER_LOW_ADDRESS_MASK = 8'hf0;

	// floppy_setup fields
	localparam int FS_PUSH_PULL = 0;
	localparam int FS_TRISTATE = 1;
	localparam int FS_NON_BURST = 2;
	localparam int FS_SWAP = 5;
	localparam int FS_EXT_DECODE = 6;

	// power_and_boot_drive fields
	localparam int PB_BOOT_LSB = 0;
	localparam int PB_APD_LSB = 4;

	// aux_control fields
	localparam int AUX_DENSITY_FORCE = 0;
	localparam int AUX_DECODER_MODE_LSB = 1;
	localparam int AUX_MIDI = 3;

	// port_control fields
	localparam int PC_PMODE_LSB = 0;
	localparam int PC_ECR_LSB = 2;

	// parallel port modes and extended control modes
	localparam logic [1:0] PMODE_ECP = 2'h2;
	localparam logic [1:0] PMODE_ECP_EPP = 2'h3;
	localparam logic [2:0] ECR_SPP = 3'h0;
	localparam logic [2:0] ECR_EPP = 3'h4;

	// general address decoder modes
	localparam logic [1:0] DEC_OFF = 2'h0;
	localparam logic [1:0] DEC_ONE_BYTE = 2'h1;
	localparam logic [1:0] DEC_EIGHT_BYTE = 2'h2;

	// serial clock divisors from the 24 MHz input
	localparam logic [3:0] SERIAL_DIV_NORMAL = 4'hd;
	localparam logic [3:0] SERIAL_DIV_MIDI = 4'hc;
	localparam logic [4:0] SERIAL_OVERSAMPLE = 5'h10;

	// requests from the floppy engine, active high
	typedef struct packed {
		logic [1:0] drive_number;
		logic drive_active;
		logic [1:0] motor_on;
		logic density_level;
		logic dma_request;
		logic interrupt_request;
		logic byte_strobe;
		logic fifo_enabled;
	} floppy_engine_t;

	// pin bundle: {second density, motor 1, motor 0, select 1, select 0}
	typedef struct packed {
		logic [4:0] out;
		logic [4:0] oe;
	} floppy_pins_t;

	typedef struct packed {
		logic cfg_state;
		logic [7:0] cfg_index;
		logic [7:0] floppy_setup;
		logic [7:0] drive_type_ids;
		logic [7:0] power_and_boot_drive;
		logic [7:0] decoder_low_address;
		logic [7:0] aux_control;
		logic [7:0] port_control;
		logic wr_pending;
		logic [3:0] word_q;
		logic [31:0] hrdata;
		floppy_pins_t fdd;
		logic [4:0] pp_floppy_out;
		logic floppy_dma_request;
		logic floppy_interrupt_request;
		logic decoder_hit;
		logic epp_select;
		logic spp_select;
	} state_t;

endpackage

// >>> superio_floppy_pm_config.sv
`timescale 1ns/100ps

// Contract
// - floppy setup reached at index 05 in config state, resets to 00.
// - setup bit 0 clear gives open-drain floppy outputs, set gives push-pull.
// - setup bit 1 set releases every floppy drive output pin.
// - bits 1 and 0 leave the parallel-port floppy signals untouched.
// - setup bit 2 set pulses dma and interrupt once per byte with fifo.
// - setup bit 5 swaps drive select 0/1 and motor select 0/1.
// - setup bit 6 set gives encoded selects for an external 2-to-4 decoder.
// - setup bit 7 is read-only and reads zero.
// - with outputs driven, force bit holds second density high; tri-state wins.
// - ecp modes drive two units directly; three or four need external decoder.
// - in ecp plus epp mode, extended control mode 100 selects epp.
// - in ecp modes, extended control mode 000 selects standard port.
// - midi enabled divides 24 MHz by 12 then 16 for 125 kbaud.
// - drive type ids at index 06, reset ff, two bits per drive.
// - power and boot register at index 07 in config state, resets to 00.
// - bits 1:0 pick boot drive, bits 3:2 read zero.
// - bits 7:4 enable auto power-down: parallel, uart2, uart1, floppy.
// - decoder low address at index 08, reset 00, bits 7:4 are address.
// - decoder low bits 3:0 ignore writes and read zero.
// - decoder mode: off, one byte, eight or sixteen byte block; needs chip select low.
module superio_floppy_pm_config
	import superio_cfg_pkg::*;
(
	input wire logic hclk, // bus clock, 125 MHz
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // word transfers only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready in
	output logic hreadyout, // never stalls
	output logic hresp, // always okay
	output logic [31:0] hrdata, // read data
	input wire floppy_engine_t engine, // floppy engine requests
	input wire logic [15:0] io_addr, // host i/o address for the decoder
	input wire logic chip_select_n, // decoder qualifier, active low
	output floppy_pins_t floppy_pins, // floppy drive pins, oe low drives
	output logic [4:0] pp_floppy_out, // floppy levels on parallel port pins
	output logic external_four_drive_select, // selects are encoded
	output logic floppy_dma_request, // dma request to host
	output logic floppy_interrupt_request, // interrupt to host
	output logic general_address_decoder, // decoder hit
	output logic [1:0] boot_drive, // boot drive field
	output logic [3:0] auto_powerdown_enable, // {floppy, uart1, uart2, parallel}
	output logic [7:0] drive_type_ids, // two bits per drive
	output logic [3:0] serial_clock_divisor, // first divider from 24 MHz
	output logic [4:0] serial_oversample, // second divider
	output logic epp_select, // parallel port runs epp
	output logic spp_select // parallel port runs standard mode
);

	state_t s;
	state_t next_s;

	// both ecp-capable parallel port modes
	function automatic logic is_ecp_mode(input logic [1:0] pmode);
		return (pmode == PMODE_ECP) || (pmode == PMODE_ECP_EPP);
	endfunction

	// indexed read; unknown index and closed config state read zero
	function automatic logic [7:0] read_indexed(input state_t st);
		logic [7:0] v;
		v = 8'h00;
		if (st.cfg_state) begin
			unique case (st.cfg_index)
				IDX_FLOPPY_SETUP: v = st.floppy_setup & FLOPPY_SETUP_MASK;
				IDX_DRIVE_TYPE_IDS: v = st.drive_type_ids;
				IDX_POWER_AND_BOOT_DRIVE: v = st.power_and_boot_drive & POWER_AND_BOOT_DRIVE_MASK;
				IDX_DECODER_LOW_ADDRESS: v = st.decoder_low_address & DECODER_LOW_ADDRESS_MASK;
				default: v = 8'h00;
			endcase
		end
		return v;
	endfunction

	// word read; unmapped words read zero
	function automatic logic [31:0] read_word(input state_t st, input logic [3:0] w);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (w)
			WORD_CONFIG_CONTROL: v = {31'h0000_0000, st.cfg_state};
			WORD_CONFIG_INDEX: v = {24'h00_0000, st.cfg_index};
			WORD_CONFIG_DATA: v = {24'h00_0000, read_indexed(st)};
			WORD_AUX_CONTROL: v = {24'h00_0000, st.aux_control};
			WORD_PORT_CONTROL: v = {24'h00_0000, st.port_control};
			WORD_PIN_STATUS: v = {14'h0000, st.decoder_hit, st.floppy_interrupt_request,
				st.floppy_dma_request, st.pp_floppy_out, st.fdd.oe, st.fdd.out};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// pin level helpers
	logic [1:0] drive_num;
	logic [1:0] motor_on;
	logic [1:0] select_pins;
	logic [4:0] levels;
	logic drive_ok;
	logic [1:0] dec_mode;
	logic dec_match;

	// drive and motor mapping; swap touches only units 0 and 1
	always_comb begin
		drive_num = engine.drive_number;
		motor_on = engine.motor_on;
		if (s.floppy_setup[FS_SWAP]) begin
			if (!engine.drive_number[1])
				drive_num = {1'b0, ~engine.drive_number[0]};
			motor_on = {engine.motor_on[0], engine.motor_on[1]};
		end
		// internal decoder only reaches units 0 and 1
		drive_ok = s.floppy_setup[FS_EXT_DECODE] || !drive_num[1];
		if (s.floppy_setup[FS_EXT_DECODE])
			select_pins = drive_num;
		else if (engine.drive_active && drive_ok)
			select_pins = drive_num[0] ? 2'b01 : 2'b10;
		else
			select_pins = 2'b11;
		// second density forced high when asked; motor and select pins are active low
		levels = {engine.density_level | s.aux_control[AUX_DENSITY_FORCE], ~motor_on, select_pins};
	end

	// general address decoder match
	always_comb begin
		dec_mode = s.aux_control[AUX_DECODER_MODE_LSB +: 2];
		dec_match = io_addr[7:4] == s.decoder_low_address[7:4];
		if (dec_mode == DEC_ONE_BYTE)
			dec_match = dec_match && (io_addr[3:0] == 4'h0);
		else if (dec_mode == DEC_EIGHT_BYTE)
			dec_match = dec_match && !io_addr[3];
		dec_match = dec_match && (dec_mode != DEC_OFF) && !chip_select_n;
	end

	// next state: bus write, address capture, then registered outputs
	always_comb begin
		next_s = s;
		next_s.wr_pending = 1'b0;
		// data phase of a write
		if (s.wr_pending) begin
			unique case (s.word_q)
				WORD_CONFIG_CONTROL: next_s.cfg_state = hwdata[0];
				WORD_CONFIG_INDEX: next_s.cfg_index = hwdata[7:0];
				WORD_AUX_CONTROL: next_s.aux_control = hwdata[7:0];
				WORD_PORT_CONTROL: next_s.port_control = hwdata[7:0];
				WORD_CONFIG_DATA: begin
					// closed config state leaves every register alone
					if (s.cfg_state) begin
						unique case (s.cfg_index)
							IDX_FLOPPY_SETUP: next_s.floppy_setup = hwdata[7:0] & FLOPPY_SETUP_MASK;
							IDX_DRIVE_TYPE_IDS: next_s.drive_type_ids = hwdata[7:0];
							IDX_POWER_AND_BOOT_DRIVE:
								next_s.power_and_boot_drive = hwdata[7:0] & POWER_AND_BOOT_DRIVE_MASK;
							IDX_DECODER_LOW_ADDRESS:
								next_s.decoder_low_address = hwdata[7:0] & DECODER_LOW_ADDRESS_MASK;
							default: next_s.floppy_setup = s.floppy_setup;
						endcase
					end
				end
				default: next_s.cfg_state = s.cfg_state;
			endcase
		end
		// address phase; read data from the updated copy so a write just before is seen
		if (hsel && htrans[1] && hready) begin
			next_s.wr_pending = hwrite;
			next_s.word_q = haddr[5:2];
			if (!hwrite)
				next_s.hrdata = read_word(next_s, haddr[5:2]);
		end
		// floppy pins: tri-state beats everything, then driver type
		for (int i = 0; i < 5; i++) begin
			if (s.floppy_setup[FS_TRISTATE]) begin
				next_s.fdd.out[i] = 1'b1;
				next_s.fdd.oe[i] = 1'b1;
			end else if (s.floppy_setup[FS_PUSH_PULL]) begin
				next_s.fdd.out[i] = levels[i];
				next_s.fdd.oe[i] = 1'b0;
			end else begin
				// open drain only pulls low; high is left to the pull-up
				next_s.fdd.out[i] = levels[i];
				next_s.fdd.oe[i] = levels[i];
			end
		end
		// parallel port copy ignores driver type and tri-state
		next_s.pp_floppy_out = levels;
		// non-burst: one pulse per byte while the fifo runs
		if (s.floppy_setup[FS_NON_BURST] && engine.fifo_enabled) begin
			next_s.floppy_dma_request = engine.byte_strobe;
			next_s.floppy_interrupt_request = engine.byte_strobe;
		end else begin
			next_s.floppy_dma_request = engine.dma_request;
			next_s.floppy_interrupt_request = engine.interrupt_request;
		end
		next_s.decoder_hit = dec_match;
		next_s.epp_select = (s.port_control[PC_PMODE_LSB +: 2] == PMODE_ECP_EPP)
			&& (s.port_control[PC_ECR_LSB +: 3] == ECR_EPP);
		next_s.spp_select = is_ecp_mode(s.port_control[PC_PMODE_LSB +: 2])
			&& (s.port_control[PC_ECR_LSB +: 3] == ECR_SPP);
	end

	// state register; pins come up released
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '0;
			s.floppy_setup <= FLOPPY_SETUP_RST;
			s.drive_type_ids <= DRIVE_TYPE_IDS_RST;
			s.power_and_boot_drive <= POWER_AND_BOOT_DRIVE_RST;
			s.decoder_low_address <= DECODER_LOW_ADDRESS_RST;
			s.aux_control <= AUX_CONTROL_RST;
			s.port_control <= PORT_CONTROL_RST;
			s.fdd.out <= 5'h1f;
			s.fdd.oe <= 5'h1f;
			s.pp_floppy_out <= 5'h1f;
		end else begin
			s <= next_s;
		end
	end

	// outputs; bus never waits and never errors
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s.hrdata;
	assign floppy_pins = s.fdd;
	assign pp_floppy_out = s.pp_floppy_out;
	assign external_four_drive_select = s.floppy_setup[FS_EXT_DECODE];
	assign floppy_dma_request = s.floppy_dma_request;
	assign floppy_interrupt_request = s.floppy_interrupt_request;
	assign general_address_decoder = s.decoder_hit;
	assign boot_drive = s.power_and_boot_drive[PB_BOOT_LSB +: 2];
	assign auto_powerdown_enable = s.power_and_boot_drive[PB_APD_LSB +: 4];
	assign drive_type_ids = s.drive_type_ids;
	// midi trades the standard rate for 24 MHz / 12 / 16
	assign serial_clock_divisor = s.aux_control[AUX_MIDI] ? SERIAL_DIV_MIDI : SERIAL_DIV_NORMAL;
	assign serial_oversample = SERIAL_OVERSAMPLE;
	assign epp_select = s.epp_select;
	assign spp_select = s.spp_select;

	// helper: read data phase of the floppy setup register
	logic rd_setup;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rd_setup <= 1'b0;
		else
			rd_setup <= hsel && htrans[1] && hready && !hwrite && haddr[5:2] == WORD_CONFIG_DATA
				&& next_s.cfg_index == IDX_FLOPPY_SETUP;
	end

	reserved_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_setup |-> hrdata[7] == 1'b0)
		else $error("floppy setup bit 7 read as one");

	tristate_pins_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s.floppy_setup[FS_TRISTATE] |=> floppy_pins.oe == 5'h1f)
		else $error("floppy pins driven while tri-stated");

	push_pull_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.floppy_setup[FS_PUSH_PULL] && !s.floppy_setup[FS_TRISTATE]) |=> floppy_pins.oe == 5'h00)
		else $error("push-pull pin released");

	open_drain_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(!s.floppy_setup[FS_PUSH_PULL] && !s.floppy_setup[FS_TRISTATE])
		|=> (floppy_pins.out & ~floppy_pins.oe) == 5'h00)
		else $error("open-drain pin driven high");

	non_burst_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.floppy_setup[FS_NON_BURST] && engine.fifo_enabled)
		|=> floppy_dma_request == $past(engine.byte_strobe) && floppy_interrupt_request == floppy_dma_request)
		else $error("non-burst request not one pulse per byte");

	density_force_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.aux_control[AUX_DENSITY_FORCE] && s.floppy_setup[FS_PUSH_PULL] && !s.floppy_setup[FS_TRISTATE])
		|=> floppy_pins.out[4] && !floppy_pins.oe[4])
		else $error("second density not held high");

	decoder_cs_a: assert property (@(posedge hclk) disable iff (!hresetn)
		chip_select_n |=> !general_address_decoder)
		else $error("decoder hit without chip select");

	locked_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.wr_pending && s.word_q == WORD_CONFIG_DATA && !s.cfg_state)
		|=> $stable(s.floppy_setup) && $stable(s.drive_type_ids) && $stable(s.power_and_boot_drive)
		&& $stable(s.decoder_low_address))
		else $error("config register changed outside config state");

	reserved_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
		s.decoder_low_address[3:0] == 4'h0 && s.power_and_boot_drive[3:2] == 2'h0)
		else $error("reserved configuration bits set");

	epp_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.port_control[1:0] == PMODE_ECP_EPP && s.port_control[4:2] == ECR_EPP) |=> epp_select ##1 epp_select
		|| !(s.port_control[1:0] == PMODE_ECP_EPP && s.port_control[4:2] == ECR_EPP))
		else $error("epp not selected");

	swap_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.floppy_setup[FS_SWAP] && s.floppy_setup[FS_PUSH_PULL] && !s.floppy_setup[FS_TRISTATE]
		&& !s.floppy_setup[FS_EXT_DECODE] && engine.drive_active && engine.drive_number == 2'h0
		&& engine.motor_on == 2'h1) |=> floppy_pins.out[3:0] == 4'h5)
		else $error("drive and motor selects not swapped");

	ext_select_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(s.floppy_setup[FS_EXT_DECODE] && s.floppy_setup[FS_PUSH_PULL] && !s.floppy_setup[FS_TRISTATE]
		&& !s.floppy_setup[FS_SWAP]) |=> floppy_pins.out[1:0] == $past(engine.drive_number))
		else $error("encoded drive number not on select pins");

	spp_only_ecp_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!is_ecp_mode(s.port_control[PC_PMODE_LSB +: 2]) |=> !spp_select)
		else $error("standard port selected outside ecp modes");

endmodule

// >>> testbench.sv
`timescale 1ns/100ps

module testbench;
	import superio_cfg_pkg::*;

	typedef struct {string name; logic [31:0] val;} note_t;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hready;
	logic hreadyout, hresp, external_four_drive_select, floppy_dma_request, floppy_interrupt_request;
	logic general_address_decoder, epp_select, spp_select;
	logic [31:0] hrdata;
	floppy_engine_t engine = '0;
	logic [15:0] io_addr = 16'h0;
	logic chip_select_n = 1'b1;
	floppy_pins_t floppy_pins;
	logic [4:0] pp_floppy_out, serial_oversample;
	logic [1:0] boot_drive;
	logic [3:0] auto_powerdown_enable, serial_clock_divisor;
	logic [7:0] drive_type_ids, v;
	note_t notes[$];
	note_t cur;
	logic rd_phase = 1'b0;
	int errors = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [7:0] idx [4] = '{IDX_FLOPPY_SETUP, IDX_DRIVE_TYPE_IDS, IDX_POWER_AND_BOOT_DRIVE, IDX_DECODER_LOW_ADDRESS};
	logic [7:0] msk [4] = '{FLOPPY_SETUP_MASK, 8'hff, POWER_AND_BOOT_DRIVE_MASK, DECODER_LOW_ADDRESS_MASK};
	// pin table: setup, aux, out, oe; open drain releases the high pins
	logic [7:0] p_set [7] = '{8'h00, 8'h01, 8'h02, 8'h21, 8'h01, 8'h03, 8'h41};
	logic [7:0] p_aux [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
	logic [4:0] p_out [7] = '{5'h0a, 5'h0a, 5'h1f, 5'h05, 5'h1a, 5'h1f, 5'h08};
	logic [4:0] p_oe [7] = '{5'h0a, 5'h00, 5'h1f, 5'h00, 5'h00, 5'h1f, 5'h00};
	// decoder table: mode, low address byte, chip select, hit
	logic [1:0] d_mode [8] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h0, 2'h3};
	logic [7:0] d_addr [8] = '{8'h50, 8'h51, 8'h57, 8'h58, 8'h5f, 8'h6f, 8'h50, 8'h50};
	logic d_cs [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
	logic d_hit [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

	assign hready = hreadyout;

	superio_floppy_pm_config superio_floppy_pm_config_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.engine(engine), .io_addr(io_addr), .chip_select_n(chip_select_n), .floppy_pins(floppy_pins),
		.pp_floppy_out(pp_floppy_out), .external_four_drive_select(external_four_drive_select),
		.floppy_dma_request(floppy_dma_request), .floppy_interrupt_request(floppy_interrupt_request),
		.general_address_decoder(general_address_decoder), .boot_drive(boot_drive),
		.auto_powerdown_enable(auto_powerdown_enable), .drive_type_ids(drive_type_ids),
		.serial_clock_divisor(serial_clock_divisor), .serial_oversample(serial_oversample),
		.epp_select(epp_select), .spp_select(spp_select)
	);

	// 125 MHz bus clock
	always #4 hclk = ~hclk;

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic print_verdict();
		if (notes.size() != 0) errors++;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// a hang anywhere ends in the same report
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			print_verdict();
		end
	end

	// read data is taken at the edge that closes the data phase
	always @(posedge hclk) begin
		if (rd_phase && hready === 1'b1) begin
			cur = notes.pop_front();
			chk(cur.name, cur.val, hrdata);
		end
		rd_phase <= hsel && htrans[1] && !hwrite && hready;
	end

	// one single transfer; no cycle count assumed, only hready
	task automatic bus(input logic wr, input logic [3:0] w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {26'h0, w, 2'h0};
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
	endtask

	task automatic rd(input logic [3:0] w, input logic [31:0] exp, input string nm);
		notes.push_back('{nm, exp});
		bus(1'b0, w, 32'h0);
	endtask

	task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
		bus(1'b1, WORD_CONFIG_INDEX, {24'h0, i});
		bus(1'b1, WORD_CONFIG_DATA, {24'h0, d});
	endtask

	task automatic cfg_rd(input logic [7:0] i, input logic [7:0] exp, input string nm);
		bus(1'b1, WORD_CONFIG_INDEX, {24'h0, i});
		rd(WORD_CONFIG_DATA, {24'h0, exp}, nm);
	endtask

	task automatic settle();
		repeat (2) @(posedge hclk);
		#1;
	endtask

	initial begin
		void'($urandom(23754));
		repeat (10) @(posedge hclk);
		hresetn <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		#1;
		chk("types_port", 8'hff, drive_type_ids);
		chk("rst_oe", 5'h1f, floppy_pins.oe);
		chk("hresp", 1'b0, hresp);
		bus(1'b1, WORD_CONFIG_CONTROL, 32'h1);
		cfg_rd(IDX_FLOPPY_SETUP, 8'h00, "setup_rst");
		cfg_rd(IDX_DRIVE_TYPE_IDS, 8'hff, "types_rst");
		cfg_rd(IDX_POWER_AND_BOOT_DRIVE, 8'h00, "power_rst");
		cfg_rd(IDX_DECODER_LOW_ADDRESS, 8'h00, "decoder_rst");
		$display("test reset done");
		// random data through each indexed register; reserved bits must stay zero
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom);
			cfg_wr(idx[i], v);
			cfg_rd(idx[i], v & msk[i], "masked");
		end
		cfg_wr(IDX_DRIVE_TYPE_IDS, 8'h1e);
		cfg_wr(IDX_POWER_AND_BOOT_DRIVE, 8'hb1);
		settle();
		chk("types_out", 8'h1e, drive_type_ids);
		chk("boot", 2'h1, boot_drive);
		chk("apd", 4'hb, auto_powerdown_enable);
		$display("test masks done");
		// closed config state: writes dropped, reads zero
		bus(1'b1, WORD_CONFIG_CONTROL, 32'h0);
		cfg_wr(IDX_POWER_AND_BOOT_DRIVE, 8'h40);
		cfg_rd(IDX_POWER_AND_BOOT_DRIVE, 8'h00, "closed_rd");
		bus(1'b1, WORD_CONFIG_CONTROL, 32'h1);
		cfg_rd(IDX_POWER_AND_BOOT_DRIVE, 8'hb1, "kept");
		$display("test closed done");
		// drive 0 selected, motor 0 on
		engine <= '{drive_number: 2'h0, drive_active: 1'b1, motor_on: 2'h1, default: 1'b0};
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, WORD_AUX_CONTROL, {24'h0, p_aux[i]});
			cfg_wr(IDX_FLOPPY_SETUP, p_set[i]);
			settle();
			chk("pin_out", p_out[i], floppy_pins.out);
			chk("pin_oe", p_oe[i], floppy_pins.oe);
			chk("ext", p_set[i][6], external_four_drive_select);
			if (i < 3) chk("pp_out", 5'h0a, pp_floppy_out);
		end
		$display("test pins done");
		// non-burst: requests follow the byte strobe, not the levels
		bus(1'b1, WORD_AUX_CONTROL, 32'h0);
		cfg_wr(IDX_FLOPPY_SETUP, 8'h04);
		engine <= '{dma_request: 1'b1, interrupt_request: 1'b1, fifo_enabled: 1'b1, default: 1'b0};
		settle();
		chk("dma_idle", 1'b0, floppy_dma_request);
		@(posedge hclk);
		engine.byte_strobe <= 1'b1;
		@(posedge hclk);
		engine.byte_strobe <= 1'b0;
		#1;
		chk("dma_pulse", 1'b1, floppy_dma_request);
		chk("irq_pulse", 1'b1, floppy_interrupt_request);
		@(posedge hclk);
		#1;
		chk("dma_end", 1'b0, floppy_dma_request);
		cfg_wr(IDX_FLOPPY_SETUP, 8'h00);
		settle();
		chk("dma_burst", 1'b1, floppy_dma_request);
		chk("irq_burst", 1'b1, floppy_interrupt_request);
		$display("test dma done");
		// decoder: upper address byte random, only the low byte compared
		cfg_wr(IDX_DECODER_LOW_ADDRESS, 8'h5a);
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, WORD_AUX_CONTROL, {29'h0, d_mode[i], 1'b0});
			io_addr <= {8'($urandom), d_addr[i]};
			chip_select_n <= d_cs[i];
			settle();
			chk("decoder", d_hit[i], general_address_decoder);
		end
		$display("test decoder done");
		// parallel port extended control modes
		bus(1'b1, WORD_PORT_CONTROL, {27'h0, ECR_EPP, PMODE_ECP_EPP});
		settle();
		chk("epp", 2'h2, {epp_select, spp_select});
		bus(1'b1, WORD_PORT_CONTROL, {27'h0, ECR_SPP, PMODE_ECP_EPP});
		settle();
		chk("spp_a", 2'h1, {epp_select, spp_select});
		bus(1'b1, WORD_PORT_CONTROL, {27'h0, ECR_SPP, PMODE_ECP});
		settle();
		chk("spp_b", 2'h1, {epp_select, spp_select});
		bus(1'b1, WORD_PORT_CONTROL, {27'h0, ECR_EPP, PMODE_ECP});
		settle();
		chk("no_epp", 2'h0, {epp_select, spp_select});
		// serial clock divisors
		bus(1'b1, WORD_AUX_CONTROL, 32'h8);
		settle();
		chk("midi_div", 4'hc, serial_clock_divisor);
		chk("oversample", 5'h10, serial_oversample);
		bus(1'b1, WORD_AUX_CONTROL, 32'h0);
		settle();
		chk("normal_div", 4'hd, serial_clock_divisor);
		// unmapped word drops writes and reads zero
		bus(1'b1, 4'hf, 32'($urandom));
		rd(4'hf, 32'h0, "unmapped");
		$display("test misc done");
		repeat (4) @(posedge hclk);
		print_verdict();
	end
endmodule
